// *** logic/speed_ref_pkg.sv ***
// speed_ref_pkg: register map, reset values and codes for the speed reference selector.
// assumes a 32-bit classic wishbone slave, word-aligned registers, 40 MHz reference clock.
package speed_ref_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_AOUT_FULL_SCALE = 8'h00;
	localparam logic [7:0] OFS_ALT_ACCEL       = 8'h04;
	localparam logic [7:0] OFS_ALT_DECEL       = 8'h08;
	localparam logic [7:0] OFS_INT_FREQ_REF    = 8'h0c;
	localparam logic [7:0] OFS_PRESET_BASE     = 8'h10;
	localparam logic [7:0] OFS_PRESET_LAST     = 8'h2c;
	localparam logic [7:0] OFS_CONTROL         = 8'h30;
	localparam logic [7:0] OFS_ACCEL1          = 8'h34;
	localparam logic [7:0] OFS_DECEL1          = 8'h38;
	localparam logic [7:0] OFS_MAX_FREQ        = 8'h3c;
	localparam logic [7:0] OFS_DIN_FUNC        = 8'h40;
	localparam logic [7:0] OFS_STATUS          = 8'h44;
	localparam logic [7:0] OFS_OUT_FREQ        = 8'h48;
	localparam logic [7:0] OFS_AOUT_MAX        = 8'h4c;
	// control field positions
	localparam int CTL_SRC_LSB  = 0;
	localparam int CTL_AOUT_LSB = 4;
	// reset values (0.1 Hz, 0.1 s, 1 % units)
	localparam logic [15:0] RST_FULL_SCALE = 16'h0064;
	localparam logic [15:0] RST_ALT_ACCEL  = 16'h00c8;
	localparam logic [15:0] RST_ALT_DECEL  = 16'h00c8;
	localparam logic [15:0] RST_INT_FREQ   = 16'h0258;
	localparam logic [15:0] RST_ACCEL1     = 16'h0064;
	localparam logic [15:0] RST_MAX_FREQ   = 16'h0258;
	localparam logic [15:0] RST_DECEL1     = 16'h0064;
	localparam logic [127:0] RST_PRESETS   = {16'h0258, 16'h01f4, 16'h0190, 16'h012c,
		16'h00c8, 16'h0064, 16'h0032, 16'h0000};
	localparam logic [15:0] MAX_FULL_SCALE = 16'h0320;
	localparam logic [15:0] MAX_RAMP_TIME  = 16'h1770;
	localparam logic [15:0] MIN_DECEL_TIME = 16'h0001;
	localparam logic [15:0] MAX_FREQ_LIMIT = 16'h0fa0;
	localparam logic [4:0]  MAX_AOUT_MODE  = 5'h17;
	localparam logic [4:0]  RST_AOUT_MODE  = 5'h00;
	// speed reference and input function codes
	localparam logic [2:0] SRC_INTERNAL = 3'h1;
	localparam logic [2:0] SRC_PRESET03 = 3'h4;
	localparam logic [4:0] FN_PRESET    = 5'h04;
	localparam logic [4:0] FN_ALT_RAMP  = 5'h05;
	localparam logic [4:0] FN_MOP_UP    = 5'h10;
	localparam logic [4:0] FN_MOP_DOWN  = 5'h11;
	// timing: ramp accumulator advances once every tick
	localparam int CLK_HZ        = 40000000;
	localparam int TICK_US       = 100;
	localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
	localparam int TICKS_PER_SEC = 1000000 / TICK_US;
	localparam int NUM_DIN       = 4;
	localparam int NUM_PRESET    = 8;
	// key handling states
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_EDIT = 2'b01
	} key_state_e;
endpackage : speed_ref_pkg

// *** logic/speed_ref_select.sv ***
// speed_ref_select: frequency command source, ramp set and analog full-scale logic.
// assumes synchronised digital inputs sampled here, wishbone master on the same clock.
`timescale 1ns/1ps
// What this block does
// RQ1: analog output maximum scaled by full-scale percent, default 100, 0..800.
// RQ2: analog mode code 0..23 picks quantity and range, default 0.
// RQ3: alternate accel time used for increases when alternate set active.
// RQ4: ramp rate equals maximum frequency divided by applicable time.
// RQ5: alternate decel time used for decreases, range 0.1..600.0 s.
// RQ6: source select 1 uses internal reference, 0..400.0 Hz, 0.1 Hz steps.
// RQ7: with source select 1, program mode arrow keys move internal reference immediately.
// RQ8: enter commits to nonvolatile store; escape restores original value by ramp.
// RQ9: motorized pot function on any input makes internal reference its reference.
// RQ10: inputs 1..3 with preset function supply a preset frequency.
// RQ11: active preset input overrides any other speed command.
// RQ12: preset zero used only when source select is option 4.
// RQ13: index from inputs 1..3, input 1 least significant, picks preset.
// RQ14: with preset selected, input 2 high picks the alternate ramp pair.
// RQ15: active alternate-ramp input forces the alternate pair regardless of index.
// RQ16: output frequency moves toward command at selected rate, re-evaluated continuously.
module speed_ref_select
	import speed_ref_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_clk_en,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	// digital inputs and keypad
	input  wire logic [3:0]  i_din,
	input  wire logic        i_prog_mode,
	input  wire logic        i_key_up,
	input  wire logic        i_key_down,
	input  wire logic        i_key_enter,
	input  wire logic        i_key_esc,
	// analog full-scale source value
	input  wire logic [15:0] i_aout_source_max,
	// outputs to ramp, analog stage, nonvolatile store
	output logic [15:0]      o_out_freq,
	output logic [15:0]      o_freq_cmd,
	output logic             o_alt_ramp,
	output logic [15:0]      o_aout_max,
	output logic [4:0]       o_aout_mode,
	output logic             o_nv_store,
	output logic [15:0]      o_nv_value
);
	typedef struct packed {
		logic [15:0] full_scale;
		logic [15:0] alt_accel;
		logic [15:0] alt_decel;
		logic [15:0] int_ref;
		logic [15:0] saved_ref;
		logic [8*16-1:0] preset;
		logic [2:0]  src;
		logic [4:0]  aout_mode;
		logic [15:0] accel1;
		logic [15:0] decel1;
		logic [15:0] max_freq;
		logic [4*5-1:0] din_fn;
		key_state_e  key;
		logic [3:0]  din_m;
		logic [3:0]  din_s;
		logic [3:0]  k_m;
		logic [3:0]  k_s;
		logic [3:0]  k_p;
		logic [15:0] tick;
		logic [31:0] accum;
		logic [15:0] out_freq;
		logic [31:0] aout_max;
		logic        nv_store;
		logic        ack;
		logic [31:0] rdat;
	} state_s;

	state_s st_q;
	state_s st_d;

	// limit a written value to its legal range
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	function automatic logic [15:0] preset_at(input logic [8*16-1:0] p, input logic [2:0] i);
		preset_at = p[i*16 +: 16];
	endfunction : preset_at

	// word-aligned address inside the preset window
	function automatic logic is_preset(input logic [7:0] a);
		is_preset = a >= OFS_PRESET_BASE && a <= OFS_PRESET_LAST && a[1:0] == 2'b00;
	endfunction : is_preset

	// slot is the word offset from the window base, not the raw address bits
	function automatic logic [2:0] preset_slot(input logic [7:0] a);
		preset_slot = 3'((a - OFS_PRESET_BASE) >> 2);
	endfunction : preset_slot

	// one keypad step, held inside 0..400.0 Hz
	function automatic logic [15:0] step_ref(input logic [15:0] v, input logic [1:0] arrows);
		if (arrows[0] && v < MAX_FREQ_LIMIT)
			step_ref = v + 16'h1;
		else if (arrows[1] && v != 16'h0)
			step_ref = v - 16'h1;
		else
			step_ref = v;
	endfunction : step_ref

	logic [3:0]  din_sync;
	logic [3:0]  keys_s;
	logic [3:0]  key_rise;
	logic [1:0]  fn_hit_preset;
	logic        any_preset_fn;
	logic        any_mop;
	logic        alt_input;
	logic [2:0]  preset_idx;
	logic        preset_active;
	logic [15:0] cmd;
	logic        alt_sel;
	logic [15:0] ramp_time;
	logic        up_dir;
	logic [31:0] step_num;
	logic [31:0] rd_word;
	logic        wr_en;
	logic [15:0] wv;

	// pins pass two flops; only the second stage is read, against metastability
	assign din_sync  = st_q.din_s;
	assign keys_s    = st_q.k_s;
	assign key_rise  = st_q.k_s & ~st_q.k_p;

	always_comb begin
		any_preset_fn = 1'b0;
		any_mop       = 1'b0;
		alt_input     = 1'b0;
		fn_hit_preset = 2'b00;
		for (int n = 0; n < NUM_DIN; n++) begin
			// RQ9: motorized pot assignment
			if (st_q.din_fn[n*5 +: 5] == FN_MOP_UP || st_q.din_fn[n*5 +: 5] == FN_MOP_DOWN)
				any_mop = 1'b1;
			// RQ15: alternate ramp input
			if (st_q.din_fn[n*5 +: 5] == FN_ALT_RAMP && din_sync[n])
				alt_input = 1'b1;
		end
		// RQ10: preset function on inputs 1..3
		for (int n = 0; n < 3; n++) begin
			if (st_q.din_fn[n*5 +: 5] == FN_PRESET)
				any_preset_fn = 1'b1;
		end
		fn_hit_preset[0] = any_preset_fn;
		fn_hit_preset[1] = any_mop;
	end

	// RQ13: index from inputs, input 1 lsb, non-preset inputs read as zero
	always_comb begin
		for (int n = 0; n < 3; n++)
			preset_idx[n] = din_sync[n] && (st_q.din_fn[n*5 +: 5] == FN_PRESET);
	end

	// RQ11: preset beats any other command
	// RQ12: preset zero only with source option 4
	assign preset_active = (preset_idx != 3'h0) ||
		(any_preset_fn && st_q.src == SRC_PRESET03);

	always_comb begin
		if (preset_active)
			cmd = preset_at(st_q.preset, preset_idx);
		// RQ6: internal reference source
		// RQ9: motorized pot reference
		else if (st_q.src == SRC_INTERNAL || any_mop)
			cmd = st_q.int_ref;
		else if (st_q.src == SRC_PRESET03)
			cmd = preset_at(st_q.preset, 3'h0);
		else
			cmd = 16'h0000;
	end

	// RQ14: input 2 picks alternate pair while preset
	// RQ15: alternate-ramp input wins
	assign alt_sel = alt_input || (preset_active && preset_idx[1]);
	assign up_dir  = cmd > st_q.out_freq;
	// RQ3: alternate accel for increases
	// RQ5: alternate decel for decreases
	assign ramp_time = up_dir ? (alt_sel ? st_q.alt_accel : st_q.accel1)
		: (alt_sel ? st_q.alt_decel : st_q.decel1);
	// RQ4: rate is maximum frequency over time
	assign step_num = 32'(st_q.max_freq) * 32'd10;

	assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !st_q.ack;
	assign wv    = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00};

	always_comb begin
		rd_word = 32'h0;
		unique case (i_wb_adr)
			OFS_AOUT_FULL_SCALE: rd_word = {16'h0, st_q.full_scale};
			OFS_ALT_ACCEL:       rd_word = {16'h0, st_q.alt_accel};
			OFS_ALT_DECEL:       rd_word = {16'h0, st_q.alt_decel};
			OFS_INT_FREQ_REF:    rd_word = {16'h0, st_q.int_ref};
			OFS_CONTROL:         rd_word = {23'h0, st_q.aout_mode, 1'b0, st_q.src};
			OFS_ACCEL1:          rd_word = {16'h0, st_q.accel1};
			OFS_DECEL1:          rd_word = {16'h0, st_q.decel1};
			OFS_MAX_FREQ:        rd_word = {16'h0, st_q.max_freq};
			OFS_DIN_FUNC:        rd_word = {12'h0, st_q.din_fn};
			OFS_STATUS:          rd_word = {24'h0, up_dir, alt_sel, preset_active,
				preset_idx, fn_hit_preset};
			OFS_OUT_FREQ:        rd_word = {16'h0, st_q.out_freq};
			OFS_AOUT_MAX:        rd_word = st_q.aout_max;
			default: begin
				if (is_preset(i_wb_adr))
					rd_word = {16'h0, preset_at(st_q.preset, preset_slot(i_wb_adr))};
			end
		endcase
	end

	always_comb begin
		st_d          = st_q;
		st_d.nv_store = 1'b0;
		st_d.din_m    = i_din;
		st_d.din_s    = st_q.din_m;
		st_d.k_m      = {i_key_esc, i_key_enter, i_key_down, i_key_up};
		st_d.k_s      = st_q.k_m;
		st_d.k_p      = keys_s;
		// single-wait-state slave: ack one cycle after request, dropped next cycle
		st_d.ack      = i_wb_cyc && i_wb_stb && !st_q.ack;
		st_d.rdat     = rd_word;
		if (wr_en) begin
			unique case (i_wb_adr)
				// RQ1: full scale kept within 0..800 percent
				OFS_AOUT_FULL_SCALE: st_d.full_scale = clamp(wv, 16'h0, MAX_FULL_SCALE);
				OFS_ALT_ACCEL:       st_d.alt_accel  = clamp(wv, 16'h0, MAX_RAMP_TIME);
				OFS_ALT_DECEL:       st_d.alt_decel  = clamp(wv, MIN_DECEL_TIME, MAX_RAMP_TIME);
				OFS_INT_FREQ_REF:    st_d.int_ref    = clamp(wv, 16'h0, MAX_FREQ_LIMIT);
				OFS_CONTROL: begin
					st_d.src = wv[CTL_SRC_LSB +: 3];
					// RQ2: mode code limited to 0..23
					st_d.aout_mode = (wv[CTL_AOUT_LSB +: 5] > MAX_AOUT_MODE) ? st_q.aout_mode
						: wv[CTL_AOUT_LSB +: 5];
				end
				OFS_ACCEL1:   st_d.accel1   = clamp(wv, 16'h0, MAX_RAMP_TIME);
				OFS_DECEL1:   st_d.decel1   = clamp(wv, MIN_DECEL_TIME, MAX_RAMP_TIME);
				OFS_MAX_FREQ: st_d.max_freq = clamp(wv, 16'h0, MAX_FREQ_LIMIT);
				OFS_DIN_FUNC: st_d.din_fn   = {i_wb_sel[2] ? i_wb_dat[19:16] : 4'h0, wv};
				default: begin
					if (is_preset(i_wb_adr))
						st_d.preset[preset_slot(i_wb_adr)*16 +: 16] = clamp(wv, 16'h0,
							MAX_FREQ_LIMIT);
				end
			endcase
		end
		// keypad edit of internal reference
		unique case (st_q.key)
			KEY_IDLE: begin
				if (i_prog_mode && st_q.src == SRC_INTERNAL && (key_rise[0] || key_rise[1])) begin
					st_d.saved_ref = st_q.int_ref;
					st_d.key       = KEY_EDIT;
					// RQ7: first arrow already moves
					st_d.int_ref   = step_ref(st_d.int_ref, key_rise[1:0]);
				end
			end
			KEY_EDIT: begin
				// RQ7: arrows change command at once
				st_d.int_ref = step_ref(st_d.int_ref, key_rise[1:0]);
				// RQ8: enter commits, escape restores
				if (key_rise[2]) begin
					st_d.nv_store = 1'b1;
					st_d.key      = KEY_IDLE;
				end else if (key_rise[3] || !i_prog_mode) begin
					st_d.int_ref = st_q.saved_ref;
					st_d.key     = KEY_IDLE;
				end
			end
		endcase
		// RQ16: ramp toward command, escape restores along this same ramp
		if (st_q.tick == 16'(TICK_CYC - 1)) begin
			st_d.tick = 16'h0;
			if (cmd == st_q.out_freq) begin
				st_d.accum = 32'h0;
			end else if (ramp_time == 16'h0) begin
				st_d.out_freq = cmd;
				st_d.accum    = 32'h0;
			end else begin
				// accumulator in units of 1/(time*ticks) of 0.1 Hz
				st_d.accum = st_q.accum + step_num;
				if (st_d.accum >= 32'(ramp_time) * 32'(TICKS_PER_SEC)) begin
					st_d.accum    = 32'h0;
					st_d.out_freq = up_dir ? st_q.out_freq + 16'h1 : st_q.out_freq - 16'h1;
				end
			end
		end else begin
			st_d.tick = st_q.tick + 16'h1;
		end
		// RQ1: scaled analog maximum, percent of source maximum
		st_d.aout_max = (32'(i_aout_source_max) * 32'(st_q.full_scale)) / 32'd100;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			st_q            <= '0;
			st_q.full_scale <= RST_FULL_SCALE;
			st_q.alt_accel  <= RST_ALT_ACCEL;
			st_q.alt_decel  <= RST_ALT_DECEL;
			st_q.int_ref    <= RST_INT_FREQ;
			st_q.accel1     <= RST_ACCEL1;
			st_q.decel1     <= RST_DECEL1;
			st_q.max_freq   <= RST_MAX_FREQ;
			st_q.aout_mode  <= RST_AOUT_MODE;
			st_q.key        <= KEY_IDLE;
			st_q.preset     <= RST_PRESETS;
		end else if (i_clk_en) begin
			st_q <= st_d;
		end
	end

	assign o_wb_ack    = st_q.ack;
	assign o_wb_dat    = st_q.rdat;
	assign o_out_freq  = st_q.out_freq;
	assign o_freq_cmd  = cmd;
	assign o_alt_ramp  = alt_sel;
	assign o_aout_max  = st_q.aout_max[15:0];
	assign o_aout_mode = st_q.aout_mode;
	assign o_nv_store  = st_q.nv_store;
	assign o_nv_value  = st_q.int_ref;

	// RQ1: full scale never exceeds limit
	a_full_scale_max: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ1
		st_q.full_scale <= MAX_FULL_SCALE) else $error("full scale out of range");
	// RQ2: mode code in range
	a_aout_mode_range: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ2
		o_aout_mode <= MAX_AOUT_MODE) else $error("analog mode out of range");
	// RQ5: decel never below minimum
	a_alt_decel_min: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ5
		st_q.alt_decel >= MIN_DECEL_TIME) else $error("alt decel below min");
	// RQ6: internal source drives command
	a_internal_cmd: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ6
		(!preset_active && st_q.src == SRC_INTERNAL) |-> o_freq_cmd == st_q.int_ref)
		else $error("internal reference not used");
	// RQ9: motorized pot takes internal reference
	a_mop_reference: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ9
		(!preset_active && any_mop) |-> o_freq_cmd == st_q.int_ref)
		else $error("motorized pot reference not used");
	// RQ11: preset overrides
	a_preset_wins: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ11
		(preset_idx != 3'h0) |-> o_freq_cmd == preset_at(st_q.preset, preset_idx))
		else $error("preset did not override");
	// RQ12: preset zero needs option 4
	a_preset_zero_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ12
		(preset_idx == 3'h0 && st_q.src != SRC_PRESET03) |-> !preset_active)
		else $error("preset zero without option 4");
	// RQ13: input 1 is index lsb
	a_index_lsb: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ13
		(st_q.din_fn[4:0] == FN_PRESET) |-> preset_idx[0] == din_sync[0])
		else $error("input 1 not index lsb");
	// RQ14: input 2 picks alternate pair
	a_preset_alt_pair: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ14
		(preset_active && preset_idx[1]) |-> o_alt_ramp) else $error("preset pair wrong");
	// RQ15: alt ramp input forces pair
	a_alt_input_pair: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ15
		alt_input |-> o_alt_ramp) else $error("alt ramp input ignored");
	// RQ8: enter stores edited value
	a_enter_stores: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ8
		(i_clk_en && st_q.key == KEY_EDIT && key_rise[2]) |=> o_nv_store)
		else $error("enter did not store");
	// RQ16: output moves at most one step per clock cycle
	a_ramp_step: assert property (@(posedge i_ref_clk) disable iff (i_srst) // RQ16
		(i_clk_en && ramp_time != 16'h0 && $stable(cmd)) |=>
		(o_out_freq - $past(o_out_freq) <= 16'h1 || $past(o_out_freq) - o_out_freq <= 16'h1))
		else $error("ramp jumped");
endmodule : speed_ref_select

// *** tb/din_keypad_model.sv ***
// din_keypad_model: digital input terminals and keypad in front of the selector.
// assumes the bench asks for a key press with a one-cycle request.
`timescale 1ns/1ps
module din_keypad_model (
	// clock
	input  wire logic       i_ref_clk,
	// bench requests
	input  wire logic [3:0] i_din_req,
	input  wire logic [3:0] i_key_req,
	// terminal and keypad levels (keys: up, down, enter, esc)
	output logic [3:0]      o_din,
	output logic [3:0]      o_keys
);
	logic [3:0] hold_q;

	initial begin
		o_din = 4'h0;
		o_keys = 4'h0;
		hold_q = 4'h0;
	end

	// keys held long enough to pass the two-flop sync, then released fully
	always @(posedge i_ref_clk) begin
		o_din <= i_din_req;
		if (i_key_req != 4'h0) begin
			o_keys <= i_key_req;
			hold_q <= 4'h6;
		end else if (hold_q != 4'h0) begin
			hold_q <= hold_q - 4'h1;
		end else begin
			o_keys <= 4'h0;
		end
	end
endmodule : din_keypad_model

// *** tb/preset_speed_reference_select_tb.sv ***
// preset_speed_reference_select_tb: self-checking bench for the speed reference selector.
// assumes the register map and reset values of speed_ref_pkg and a short ramp tick.
`timescale 1ns/1ps
module preset_speed_reference_select_tb;
	import speed_ref_pkg::*;
	typedef struct packed {logic [7:0] adr; logic [15:0] val;} row_s;
	logic        clk, srst, cyc, stb, we, ack, alt, nv, prog, ce;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0]  sel, din_req, key_req, din, keys;
	logic [15:0] src_max, out_f, cmd, amax, nv_val, start;
	logic [4:0]  amode;
	int          miscompares, checks_done, nv_count, n0;
	row_s        rows [12];

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	din_keypad_model partner (.i_ref_clk(clk), .i_din_req(din_req), .i_key_req(key_req),
		.o_din(din), .o_keys(keys));

	speed_ref_select #(.TICK_CYC(4)) dut (.i_ref_clk(clk), .i_srst(srst), .i_clk_en(ce),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat), .i_din(din), .i_prog_mode(prog),
		.i_key_up(keys[0]), .i_key_down(keys[1]), .i_key_enter(keys[2]), .i_key_esc(keys[3]),
		.i_aout_source_max(src_max), .o_out_freq(out_f), .o_freq_cmd(cmd), .o_alt_ramp(alt),
		.o_aout_max(amax), .o_aout_mode(amode), .o_nv_store(nv), .o_nv_value(nv_val));

	always @(posedge clk) if (nv === 1'b1) nv_count++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s: got %h want %h", $time, msg, got, exp);
		end
	endtask : chk

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : wb

	task automatic press(input logic [3:0] k);
		key_req <= k;
		@(posedge clk);
		key_req <= 4'h0;
		repeat (14) @(posedge clk);
	endtask : press

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish;
	end

	initial begin
		rows = '{'{8'h00, 16'h0064}, '{8'h04, 16'h00c8}, '{8'h08, 16'h00c8},
			'{8'h0c, 16'h0258}, '{8'h10, 16'h0000}, '{8'h14, 16'h0032}, '{8'h18, 16'h0064},
			'{8'h1c, 16'h00c8}, '{8'h20, 16'h012c}, '{8'h24, 16'h0190}, '{8'h28, 16'h01f4},
			'{8'h2c, 16'h0258}};
		srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
		sel = 4'h0; din_req = 4'h0; key_req = 4'h0; prog = 1'b0; src_max = 16'd1000;
		miscompares = 0; checks_done = 0; nv_count = 0; ce = 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			wb(1'b0, rows[i].adr, 32'h0, q);
			chk(q, {16'h0, rows[i].val}, "reset value");
		end
		wb(1'b0, 8'h80, 32'h0, q);
		chk(q, 32'h0, "unmapped read");
		$display("test reset_values done");
		wb(1'b1, OFS_DIN_FUNC, 32'h1084, q);
		wb(1'b1, OFS_CONTROL, 32'h4, q);
		for (int i = 0; i < 8; i++) begin
			din_req <= i[3:0];
			repeat (8) @(posedge clk);
			chk({16'h0, cmd}, {16'h0, rows[4 + i].val}, "preset command");
			chk(32'(alt), 32'(i[1]), "preset ramp set");
		end
		$display("test preset_table done");
		wb(1'b1, OFS_CONTROL, 32'h1, q);
		din_req <= 4'h0;
		repeat (8) @(posedge clk);
		chk({16'h0, cmd}, 32'd600, "index 0 without option 4");
		din_req <= 4'h3;
		repeat (8) @(posedge clk);
		chk({16'h0, cmd}, 32'd200, "preset over internal");
		wb(1'b1, OFS_CONTROL, 32'h4, q);
		wb(1'b1, OFS_ACCEL1, 32'h0, q);
		wb(1'b1, OFS_DECEL1, 32'h0, q);
		din_req <= 4'h0;
		repeat (20) @(posedge clk);
		chk({16'h0, out_f}, 32'h0, "zero time jump");
		wb(1'b1, OFS_ACCEL1, 32'd6000, q);
		wb(1'b1, OFS_DECEL1, 32'd6000, q);
		wb(1'b1, OFS_ALT_ACCEL, 32'd6, q);
		wb(1'b1, OFS_ALT_DECEL, 32'd12, q);
		// one step per 40 cycles on the alternate accel of 0.6 s
		din_req <= 4'h2;
		repeat (2008) @(posedge clk);
		chk(32'(out_f >= 16'd46 && out_f <= 16'd54), 32'h1, "alt accel rate");
		wb(1'b1, OFS_DIN_FUNC, 32'h29084, q);
		start = out_f;
		din_req <= 4'h8;
		repeat (1608) @(posedge clk);
		chk(32'(alt), 32'h1, "alt ramp input forces set");
		n0 = int'(start) - int'(out_f);
		chk(32'(n0 >= 17 && n0 <= 23), 32'h1, "alt decel rate");
		// ramp still falling, so a missed freeze shows as a step
		ce <= 1'b0;
		@(posedge clk);
		start = out_f;
		repeat (400) @(posedge clk);
		chk({16'h0, out_f}, {16'h0, start}, "clock enable freeze");
		ce <= 1'b1;
		$display("test ramp done");
		wb(1'b1, OFS_AOUT_FULL_SCALE, 32'd50, q);
		repeat (4) @(posedge clk);
		chk({16'h0, amax}, 32'd500, "half scale");
		wb(1'b1, OFS_AOUT_FULL_SCALE, 32'd900, q);
		wb(1'b0, OFS_AOUT_FULL_SCALE, 32'h0, q);
		chk(q, 32'h320, "scale clamp");
		wb(1'b1, OFS_CONTROL, 32'h174, q);
		repeat (4) @(posedge clk);
		chk(32'(amode), 32'd23, "mode 23");
		wb(1'b1, OFS_CONTROL, 32'h184, q);
		repeat (4) @(posedge clk);
		chk(32'(amode), 32'd23, "mode 24 refused");
		$display("test analog done");
		wb(1'b1, OFS_DIN_FUNC, 32'h0, q);
		wb(1'b1, OFS_CONTROL, 32'h1, q);
		din_req <= 4'h0;
		prog <= 1'b1;
		repeat (8) @(posedge clk);
		chk({16'h0, cmd}, 32'd600, "internal reference");
		press(4'h1);
		chk({16'h0, cmd}, 32'd601, "up arrow");
		n0 = nv_count;
		press(4'h4);
		chk(32'(nv_count - n0), 32'h1, "enter stores");
		chk({16'h0, nv_val}, 32'd601, "stored value");
		press(4'h1);
		press(4'h8);
		chk({16'h0, cmd}, 32'd601, "escape restores");
		$display("test keypad done");
		prog <= 1'b0;
		wb(1'b1, OFS_CONTROL, 32'h0, q);
		wb(1'b1, OFS_DIN_FUNC, 32'h10, q);
		chk({16'h0, cmd}, 32'd601, "motorized pot reference");
		$display("test motorized_pot done");
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		chk({16'h0, out_f}, 32'h0, "reset output");
		chk(32'(amode), 32'h0, "reset mode");
		srst <= 1'b0;
		wb(1'b0, OFS_AOUT_FULL_SCALE, 32'h0, q);
		chk(q, 32'h64, "scale after reset");
		$display("test second_reset done");
		tally_and_finish;
	end
endmodule : preset_speed_reference_select_tb
